// File: inc/se2ws_pkg.sv
// constants and types shared by the two-wire serial memory slave
// assumes a 100 MHz reference clock and a master-driven serial clock
package se2ws_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int MEM_BYTES = 4096;
    localparam int ADDR_W = 12;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam int ADDR_HI_W = 4;
    // ------------------------------------------------------------
    // slave address byte layout
    // ------------------------------------------------------------
    localparam logic [3:0] TYPE_CODE = 4'hA;
    localparam int TYPE_LSB = 4;
    localparam int STRAP_LSB = 1;
    localparam int RW_BIT = 0;
    localparam logic RW_READ = 1'h1;
    // ------------------------------------------------------------
    // frame positions, counted in serial clock rising edges
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h9;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WR_CYCLE_US = 5000;
    localparam int WR_CYCLE_CNT = WR_CYCLE_US * 1000 / CLK_PERIOD_NS;
    localparam int SCL_MAX_KHZ = 1000;
    localparam int SCL_OVERSAMPLE = 1000000 / (SCL_MAX_KHZ * CLK_PERIOD_NS);
    localparam int FIFO_DEPTH = 16;
    // ------------------------------------------------------------
    // frame states
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DEV = 6'h02,
        ST_AHI = 6'h04,
        ST_ALO = 6'h08,
        ST_WR = 6'h10,
        ST_RD = 6'h20
    } se2ws_state_e;
endpackage

// File: src/se2ws_top.sv
// two-wire serial memory slave: bit sampler, frame engine, page buffer
// assumes pads with pull-downs on straps and write protect, pull-up on sda
//
// Contract
// - array holds 4096 bytes grouped in pages of 32.
// - page writes up to 32 bytes, partial pages accepted.
// - programming is self-timed and ends within 5 ms.
// - serial clock may run at up to 1 MHz.
// - write protect high at the stop blocks array programming.
// - write protect low lets writes proceed normally.
// - three strap inputs select one of eight bus positions.
// - unconnected strap inputs read as zero.
// - bus ignored during power-on reset; release enters standby.
// - reset asserted again returns the device to standby.
// - stop enters standby unless programming runs; then after it.
// - slave byte, then memory address bytes, then data bytes.
// - data line only pulled low or released, never driven high.
// - serial clock alone times bits on the data line.
// - slave byte must match type code and straps to be acknowledged.
// - lowest slave byte bit selects read (one) or write (zero).
// - slave address is not acknowledged while programming runs.
// - page write steps only five low address bits, wrapping in page.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// synchronous fifo between frame engine and page buffer
// ----------------------------------------------------------------
module se2ws_fifo
#(
    parameter int W = 13,
    parameter int D = 16
)
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    logic wr_en;
    logic rd_en;

    assign in_ready_out = (cnt_reg != (AW+1)'(D));
    assign out_valid_out = (cnt_reg != '0);
    assign out_data_out = mem[rptr_reg];
    assign wr_en = in_valid_in && in_ready_out;
    assign rd_en = out_valid_out && out_ready_in;

    // storage has no reset; occupancy decides what is valid
    always_ff @(posedge ref_clk_in)
    begin
        if (wr_en)
        begin
            mem[wptr_reg] <= in_data_in;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (wr_en)
                wptr_reg <= (wptr_reg == AW'(D-1)) ? '0 : AW'(wptr_reg + 1'b1);
            if (rd_en)
                rptr_reg <= (rptr_reg == AW'(D-1)) ? '0 : AW'(rptr_reg + 1'b1);
            cnt_reg <= (AW+1)'(cnt_reg + wr_en - rd_en);
        end
    end
endmodule

// ----------------------------------------------------------------
// top level
// ----------------------------------------------------------------
module se2ws_top
    import se2ws_pkg::*;
#(
    parameter int WR_CYCLES = WR_CYCLE_CNT
)
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic bus_position_strap_bit0_in,
    input wire logic bus_position_strap_bit1_in,
    input wire logic bus_position_strap_bit2_in,
    input wire logic wp_in,
    output logic busy_out,
    output logic standby_out
);
    localparam int TW = $clog2(WR_CYCLES);
    localparam int FW = PAGE_W + 8;
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask_reg;
    logic rx_bit_reg, rx_tog_reg;
    logic [2:0] tog_s, sda_s, scl_s, strap_s1, strap_s2;
    logic wp_s1, wp_s2;
    se2ws_state_e st_reg;
    logic [3:0] rcnt_reg;
    logic [7:0] sh_reg, tx_reg, rd_byte;
    logic rw_reg, sda_oe_n_reg, sda_out_reg, busy_reg, wr_pend_reg, standby_reg;
    logic [ADDR_W-1:0] ptr_reg, nxt_addr;
    logic [TW-1:0] tmr_reg;
    logic rx_evt, start_det, stop_det, scl_fall, byte_end, frame_end;
    logic dev_hit, ack_now, push, commit, discard, rd_go;
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [FW-1:0] f_out_data;

    // ------------------------------------------------------------
    // link domain: sample the data line on each serial clock rise
    // ------------------------------------------------------------
    // one bit per rise; the toggle tells the reference side a bit landed,
    // and the bit stays put for a whole serial period, long enough to read
    always_ff @(posedge scl_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rx_bit_reg <= 1'h0;
            rx_tog_reg <= 1'h0;
        end
        else
        begin
            rx_bit_reg <= sda_in;
            rx_tog_reg <= ~rx_tog_reg;
        end
    end

    // ------------------------------------------------------------
    // synchronisers into the reference domain
    // ------------------------------------------------------------
    // bus idles high, so line syncs reset to one to avoid a false start;
    // 100 samples per serial period leave ample margin at full rate
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            tog_s <= 3'h0;
            sda_s <= 3'h7;
            scl_s <= 3'h7;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            wp_s1 <= 1'h0;
            wp_s2 <= 1'h0;
        end
        else
        begin
            tog_s <= {tog_s[1:0], rx_tog_reg};
            sda_s <= {sda_s[1:0], sda_in};
            scl_s <= {scl_s[1:0], scl_clk_in};
            // floating straps are pulled down at the pad
            strap_s1 <= {bus_position_strap_bit2_in, bus_position_strap_bit1_in,
                bus_position_strap_bit0_in};
            strap_s2 <= strap_s1;
            wp_s1 <= wp_in;
            wp_s2 <= wp_s1;
        end
    end

    // bus events, read only from second and third stages
    assign rx_evt = tog_s[2] ^ tog_s[1];
    assign start_det = scl_s[1] && sda_s[2] && !sda_s[1];
    assign stop_det = scl_s[1] && !sda_s[2] && sda_s[1];
    assign scl_fall = scl_s[2] && !scl_s[1];
    assign byte_end = scl_fall && (rcnt_reg == BIT_LAST);
    assign frame_end = scl_fall && (rcnt_reg == ACK_BIT);

    // ------------------------------------------------------------
    // acknowledge decisions
    // ------------------------------------------------------------
    assign dev_hit = (sh_reg[7:TYPE_LSB] == TYPE_CODE)
        && (sh_reg[TYPE_LSB-1:STRAP_LSB] == strap_s2)
        && !busy_reg;
    assign ack_now = ((st_reg == ST_DEV) && dev_hit) || (st_reg == ST_AHI)
        || (st_reg == ST_ALO) || ((st_reg == ST_WR) && f_in_ready);
    assign push = byte_end && (st_reg == ST_WR) && f_in_ready;
    assign rd_go = ((st_reg == ST_DEV) && (rw_reg == RW_READ))
        || ((st_reg == ST_RD) && !sh_reg[0]);
    assign nxt_addr = (st_reg == ST_DEV) ? ptr_reg : ADDR_W'(ptr_reg + 1'b1);
    assign rd_byte = mem[nxt_addr];
    assign commit = busy_reg && (tmr_reg == TW'(WR_CYCLES - 1));
    assign discard = stop_det && wr_pend_reg && wp_s2;

    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    // start and stop override everything, so a master can always recover
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_reg <= ST_IDLE;
            rcnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            rw_reg <= 1'h0;
        end
        else if (start_det)
        begin
            st_reg <= ST_DEV;
            rcnt_reg <= 4'h0;
        end
        else if (stop_det)
        begin
            st_reg <= ST_IDLE;
            rcnt_reg <= 4'h0;
        end
        else
        begin
            if (rx_evt && (st_reg != ST_IDLE))
            begin
                rcnt_reg <= 4'(rcnt_reg + 1'b1);
                sh_reg <= {sh_reg[6:0], rx_bit_reg};
            end
            if (byte_end && (st_reg == ST_DEV))
            begin
                rw_reg <= sh_reg[RW_BIT];
                if (!dev_hit)
                    st_reg <= ST_IDLE;
            end
            if (frame_end)
            begin
                rcnt_reg <= 4'h0;
                unique case (st_reg)
                    ST_DEV: st_reg <= (rw_reg == RW_READ) ? ST_RD : ST_AHI;
                    ST_AHI: st_reg <= ST_ALO;
                    ST_ALO: st_reg <= ST_WR;
                    ST_WR: st_reg <= ST_WR;
                    ST_RD: st_reg <= rd_go ? ST_RD : ST_IDLE;
                    default: st_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // address pointer: reads step all 12 bits, writes stay inside the page
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ptr_reg <= '0;
        else if (byte_end && (st_reg == ST_AHI))
            ptr_reg[ADDR_W-1:8] <= sh_reg[ADDR_HI_W-1:0];
        else if (byte_end && (st_reg == ST_ALO))
            ptr_reg[7:0] <= sh_reg;
        else if (push)
            ptr_reg[PAGE_W-1:0] <= PAGE_W'(ptr_reg[PAGE_W-1:0] + 1'b1);
        else if (frame_end && (st_reg == ST_RD))
            ptr_reg <= ADDR_W'(ptr_reg + 1'b1);
    end

    // byte to shift out, fetched at the frame boundary before a read byte
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            tx_reg <= 8'h00;
        else if (frame_end && rd_go)
            tx_reg <= rd_byte;
    end

    // ------------------------------------------------------------
    // open-drain data line, changed only while the serial clock is low
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sda_oe_n_reg <= 1'h1;
            sda_out_reg <= 1'h0;
        end
        else
        begin
            sda_out_reg <= 1'h0;
            if (start_det || stop_det)
                sda_oe_n_reg <= 1'h1;
            else if (byte_end)
                sda_oe_n_reg <= (st_reg == ST_RD) || !ack_now;
            else if (frame_end)
                sda_oe_n_reg <= rd_go ? rd_byte[7] : 1'h1;
            else if (scl_fall && (st_reg == ST_RD) && (rcnt_reg != 4'h0))
                sda_oe_n_reg <= tx_reg[3'(4'h7 - rcnt_reg)];
        end
    end

    // ------------------------------------------------------------
    // write buffering and programming cycle
    // ------------------------------------------------------------
    // the drain stalls only in the commit cycle, so a burst never overflows
    assign f_out_ready = !commit;

    se2ws_fifo #(.W(FW), .D(FIFO_DEPTH)) u_fifo (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(byte_end && (st_reg == ST_WR)),
        .in_ready_out(f_in_ready),
        .in_data_in({ptr_reg[PAGE_W-1:0], sh_reg}),
        .out_valid_out(f_out_valid),
        .out_ready_in(f_out_ready),
        .out_data_out(f_out_data)
    );

    // pending write, busy flag and self-timed program counter
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_pend_reg <= 1'h0;
            busy_reg <= 1'h0;
            tmr_reg <= '0;
        end
        else
        begin
            if (commit)
            begin
                busy_reg <= 1'h0;
                tmr_reg <= '0;
            end
            else if (busy_reg)
                tmr_reg <= TW'(tmr_reg + 1'b1);
            // a stop in the commit cycle is written last, so the set wins
            if (stop_det && wr_pend_reg)
            begin
                wr_pend_reg <= 1'h0;
                busy_reg <= !wp_s2;
            end
            else if (push)
                wr_pend_reg <= 1'h1;
        end
    end

    // page latches; later bytes at the same offset overwrite earlier ones
    always_ff @(posedge ref_clk_in)
    begin
        if (f_out_valid && f_out_ready)
            pbuf[f_out_data[FW-1:8]] <= f_out_data[7:0];
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            pmask_reg <= '0;
        else if (commit || discard)
            pmask_reg <= '0;
        else if (f_out_valid && f_out_ready)
            pmask_reg[f_out_data[FW-1:8]] <= 1'h1;
    end

    // whole page lands at the end of the cycle; untouched bytes keep data
    always_ff @(posedge ref_clk_in)
    begin
        if (commit)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                if (pmask_reg[i])
                    mem[{ptr_reg[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
            end
        end
    end

    // standby once the frame is over and nothing is programming
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            standby_reg <= 1'h1;
        else
            standby_reg <= (st_reg == ST_IDLE) && !busy_reg;
    end

    assign sda_out = sda_out_reg;
    assign sda_oe_n_out = sda_oe_n_reg;
    assign busy_out = busy_reg;
    assign standby_out = standby_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    busy_nack_a: assert property (
        byte_end && (st_reg == ST_DEV) && busy_reg |=> sda_oe_n_reg && (st_reg == ST_IDLE))
        else $error("address acknowledged while programming");
    addr_match_a: assert property (
        byte_end && (st_reg == ST_DEV) && !busy_reg
        && (sh_reg[7:1] == {TYPE_CODE, strap_s2}) |=> !sda_oe_n_reg)
        else $error("matching slave byte not acknowledged");
    wp_block_a: assert property (
        stop_det && wp_s2 && !busy_reg |=> !busy_reg [*2])
        else $error("programming started under write protect");
    prog_start_a: assert property (
        stop_det && wr_pend_reg && !wp_s2 && !busy_reg |=> busy_reg && !standby_out)
        else $error("write did not start programming");
    prog_time_a: assert property (
        busy_reg |-> tmr_reg <= TW'(WR_CYCLES - 1))
        else $error("programming ran past its limit");
    page_wrap_a: assert property (
        push |=> (ptr_reg[ADDR_W-1:PAGE_W] == $past(ptr_reg[ADDR_W-1:PAGE_W]))
        && (ptr_reg[PAGE_W-1:0] == PAGE_W'($past(ptr_reg[PAGE_W-1:0]) + 1'b1)))
        else $error("page write pointer left its page");
    stop_idle_a: assert property (
        stop_det && !wr_pend_reg && !busy_reg |=> ##1 standby_out)
        else $error("no standby after stop");
    idle_release_a: assert property (
        (st_reg == ST_IDLE) |-> sda_oe_n_reg && !sda_out_reg)
        else $error("data line held while idle");
    addr_order_a: assert property (
        frame_end && (st_reg == ST_AHI) && !start_det && !stop_det |=> st_reg == ST_ALO)
        else $error("address bytes out of order");

    prog_c: cover property (commit && (pmask_reg != '0));
    read_c: cover property (frame_end && (st_reg == ST_RD) && sh_reg[0]);
    poll_c: cover property (byte_end && (st_reg == ST_DEV) && busy_reg);
    wp_c: cover property (discard);
endmodule

// File: tb/se2ws_master.sv
// behavioural two-wire bus master: serial clock, start, stop and bytes
// assumes the bench resolves the data line with a pull-up and
// that tasks are entered just after a falling reference clock edge
`timescale 1ns/1ns

module se2ws_master
(
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    // ------------------------------------------------------------
    // bus timing: 1 MHz serial clock, quarter steps of 250 ns
    // ------------------------------------------------------------
    localparam int QTR = 250;

    // clock stands high and data is released outside frames
    initial
    begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end

    // start or repeated start: data falls while the clock is high
    task automatic start();
    begin
        sda_oe_n_out = 1'b1;
        #QTR scl_out = 1'b1;
        #QTR sda_oe_n_out = 1'b0;
        #QTR scl_out = 1'b0;
        #QTR;
    end
    endtask

    // stop: data rises while the clock is high, clock then stands
    task automatic stop();
    begin
        sda_oe_n_out = 1'b0;
        #QTR scl_out = 1'b1;
        #QTR sda_oe_n_out = 1'b1;
        #QTR;
    end
    endtask

    // one bit: data changes only while the clock is low
    task automatic bit_x(input logic b, output logic s);
    begin
        sda_oe_n_out = b;
        #QTR scl_out = 1'b1;
        #QTR s = sda_in;
        #QTR scl_out = 1'b0;
        #QTR;
    end
    endtask

    // byte msb first, ack level returned (0 = acked)
    task automatic wr_byte(input logic [7:0] d, output logic ack);
    begin
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], ack);
        bit_x(1'b1, ack);
    end
    endtask

    // byte in msb first, then ack (0) or nack (1) on the last one
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(last, s);
    end
    endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the two-wire serial memory slave
// assumes a master model drives the serial clock at 1 MHz, right at
// the sampler's limit, so the link clock runs at that rate
`timescale 1ns/1ns

module testbench
    import se2ws_pkg::*;
;
    // ------------------------------------------------------------
    // settings and wiring
    // ------------------------------------------------------------
    localparam int WRC = 1500; // long enough to poll once
    localparam int LIMIT = 100000; // run needs about 79000 cycles
    localparam logic [2:0] STRAP = 3'h5;
    typedef struct {logic [15:0] wa; logic [15:0] ra; logic [7:0] d;} se2ws_row_s;
    se2ws_row_s rows [3] = '{'{16'h0000, 16'h0000, 8'h5A},
        '{16'hF345, 16'h0345, 8'hC3}, '{16'h0FFF, 16'h0FFF, 8'h81}};
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] strap = STRAP;
    logic wp = 1'b0;
    logic scl, m_oe_n, d_oe_n, d_sda, busy, standby, sda, ack;
    logic [7:0] q [4];
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;

    // open-drain line with pull-up: low if either party pulls
    assign sda = (d_oe_n === 1'b0 || m_oe_n === 1'b0) ? 1'b0 : 1'b1;
    always #5 ref_clk = ~ref_clk;

    se2ws_top #(.WR_CYCLES(WRC)) u_dut (.ref_clk_in(ref_clk), .nrst_in(nrst),
        .scl_clk_in(scl), .sda_in(sda), .sda_out(d_sda), .sda_oe_n_out(d_oe_n),
        .bus_position_strap_bit0_in(strap[0]), .bus_position_strap_bit1_in(strap[1]),
        .bus_position_strap_bit2_in(strap[2]), .wp_in(wp), .busy_out(busy),
        .standby_out(standby));
    se2ws_master u_mst (.sda_in(sda), .scl_out(scl), .sda_oe_n_out(m_oe_n));

    // ------------------------------------------------------------
    // compare, report and bus helpers
    // ------------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp, input string what);
    begin
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    begin
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    end
    endtask

    task automatic results();
    begin
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    function automatic logic [7:0] dev(input logic [2:0] s, input logic rd);
        return {TYPE_CODE, s, rd};
    endfunction

    // address-only frame, returns the slave ack level
    task automatic probe(input logic [7:0] b, output logic a);
    begin
        u_mst.start();
        u_mst.wr_byte(b, a);
        u_mst.stop();
    end
    endtask

    task automatic set_ptr(input logic [15:0] a);
    begin
        u_mst.start();
        u_mst.wr_byte(dev(STRAP, 1'b0), ack);
        chk_bit(ack, 1'b0, "slave ack");
        u_mst.wr_byte(a[15:8], ack);
        chk_bit(ack, 1'b0, "addr hi ack");
        u_mst.wr_byte(a[7:0], ack);
        chk_bit(ack, 1'b0, "addr lo ack");
    end
    endtask

    // stop, then busy, a refused poll, the cycle length and standby
    task automatic wait_prog();
        time t0;
    begin
        t0 = $time - 250; // the stop edge lies one quarter step back
        repeat (10) @(negedge ref_clk);
        chk_bit(busy, 1'b1, "busy after stop");
        chk_bit(standby, 1'b0, "standby while busy");
        probe(dev(STRAP, 1'b0), ack);
        chk_bit(ack, 1'b1, "poll refused");
        for (int n = 0; n < 2 * WRC && busy !== 1'b0; n++)
            @(negedge ref_clk);
        t0 = ($time - t0) / 10;
        chk_bit(t0 >= WRC - 5 && t0 <= WRC + 20, 1'b1, "cycle length");
        repeat (3) @(negedge ref_clk);
        chk_bit(standby, 1'b1, "standby after cycle");
    end
    endtask

    task automatic wr_mem(input logic [15:0] a, input logic [7:0] d [4], input int n);
    begin
        set_ptr(a);
        for (int i = 0; i < n; i++)
        begin
            u_mst.wr_byte(d[i], ack);
            chk_bit(ack, 1'b0, "data ack");
        end
        u_mst.stop();
    end
    endtask

    task automatic rd_mem(input logic [15:0] a, input int n);
    begin
        set_ptr(a);
        u_mst.start();
        u_mst.wr_byte(dev(STRAP, 1'b1), ack);
        chk_bit(ack, 1'b0, "read slave ack");
        for (int i = 0; i < n; i++)
            u_mst.rd_byte(i == n - 1, q[i]);
        u_mst.stop();
    end
    endtask

    // ------------------------------------------------------------
    // main sequence: table rows first, then the awkward cases
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(negedge ref_clk);
        chk_bit(d_oe_n, 1'b1, "line in reset");
        chk_bit(standby, 1'b1, "standby in reset");
        chk_bit(busy, 1'b0, "busy in reset");
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (5) @(negedge ref_clk);
        for (int i = 0; i < 3; i++)
        begin
            wr_mem(rows[i].wa, '{rows[i].d, 8'h00, 8'h00, 8'h00}, 1);
            wait_prog();
            rd_mem(rows[i].ra, 1);
            chk_byte(q[0], rows[i].d, "row data");
        end
        // current read after the top byte wraps the pointer to zero
        u_mst.start();
        u_mst.wr_byte(dev(STRAP, 1'b1), ack);
        u_mst.rd_byte(1'b1, q[0]);
        u_mst.stop();
        chk_byte(q[0], 8'h5A, "pointer wrap");
        chk_bit(d_sda, 1'b0, "line never driven high");
        // partial page that runs over the page end
        wr_mem(16'h011E, '{8'hA1, 8'hA2, 8'hA3, 8'h00}, 3);
        wait_prog();
        rd_mem(16'h011E, 2);
        chk_byte(q[0], 8'hA1, "page byte 30");
        chk_byte(q[1], 8'hA2, "page byte 31");
        rd_mem(16'h0100, 1);
        chk_byte(q[0], 8'hA3, "page wrap");
        // write protect: bytes acked, nothing programmed
        wp = 1'b1;
        repeat (5) @(negedge ref_clk);
        wr_mem(16'h0000, '{8'h00, 8'h00, 8'h00, 8'h00}, 1);
        repeat (30) @(negedge ref_clk);
        chk_bit(busy, 1'b0, "no cycle when protected");
        wp = 1'b0;
        rd_mem(16'h0000, 1);
        chk_byte(q[0], 8'h5A, "protected data kept");
        // every strap value, own address and its complement
        for (int s = 0; s < 8; s++)
        begin
            strap = 3'(s);
            repeat (5) @(negedge ref_clk);
            probe(dev(3'(s), 1'b0), ack);
            chk_bit(ack, 1'b0, "own position");
            probe(dev(3'(s) ^ 3'h7, 1'b0), ack);
            chk_bit(ack, 1'b1, "other position");
        end
        strap = STRAP;
        // reset again in mid frame, bus ignored until release
        u_mst.start();
        u_mst.wr_byte(dev(STRAP, 1'b0), ack);
        nrst = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk_bit(standby, 1'b1, "standby on reset");
        chk_bit(d_oe_n, 1'b1, "line freed on reset");
        u_mst.stop();
        probe(dev(STRAP, 1'b0), ack);
        chk_bit(ack, 1'b1, "ignored in reset");
        nrst = 1'b1;
        repeat (5) @(negedge ref_clk);
        probe(dev(STRAP, 1'b0), ack);
        chk_bit(ack, 1'b0, "answers after release");
        results();
    end

    // hang guard: a run past the ceiling counts as a mismatch
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_fail++;
            $display("MISMATCH %0t timeout", $time);
            results();
        end
    end
endmodule
